// ---- core/sev_pkg.sv ----
// Constants, types and register map of the dual-channel safety output evaluator
// Summary of operation
// - Any channel OFF puts machine safe
// - Both channels sampled and processed separately
// - Flag channel disagreement beyond discrepancy time
// - After trip, stay off until reset button
// - Reset only on full press then release
// - Stuck or jammed reset button never re-enables
// - Switch-on only with both feedbacks de-energized
// - Check contactors drop out when channels OFF
// - Energize contactors after reset, drop on interruption
// - Tripped lamp on trip, ready lamp flashes
// - Cross or short circuit enters latched lock-out
// - Detect contactor malfunction, keep switch-off effective
package sev_pkg;

  // Clock and base tick
  localparam int CLK_MHZ      = 50;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYC     = TICK_US * CLK_MHZ;

  // Times in ticks of 1 ms
  localparam logic [15:0] DISC_MS_RST  = 16'h0064;
  localparam logic [11:0] EDM_MS       = 12'h12C;
  localparam logic [11:0] BTN_MIN_MS   = 12'h032;
  localparam logic [11:0] BTN_MAX_MS   = 12'hBB8;
  localparam logic [7:0]  FLASH_MS     = 8'hFA;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;
  localparam logic [7:0] ADDR_DISC   = 8'h10;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // Status bit positions
  localparam int ST_TRIP_B  = 0;
  localparam int ST_DISC_B  = 1;
  localparam int ST_EDM_B   = 2;
  localparam int ST_STUCK_B = 3;
  localparam int ST_LOCK_B  = 4;
  localparam int ST_READY_B = 5;
  localparam int ST_W       = 6;

  // Control bit positions
  localparam int CTRL_RUN_EN_B = 0;

  typedef enum logic [3:0] {
    SEV_TRIP  = 4'b0001,
    SEV_READY = 4'b0010,
    SEV_RUN   = 4'b0100,
    SEV_LOCK  = 4'b1000
  } sev_state_t;

  // Pins from the field
  typedef struct packed {
    logic safety_out_a;
    logic safety_out_b;
    logic feedback_a;
    logic feedback_b;
    logic reset_pushbutton;
  } sev_pins_in_t;

  // Pins to the field
  typedef struct packed {
    logic contactor_a;
    logic contactor_b;
    logic tripped_lamp;
    logic reset_ready_lamp;
  } sev_pins_out_t;

endpackage : sev_pkg

// ---- core/sev_sync.sv ----
// Two-flop synchroniser for field inputs
`timescale 1ns/1ps
module sev_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q_sync   <= '0;
    end else begin
      meta_reg <= d_async;
      q_sync   <= meta_reg;
    end
  end

endmodule : sev_sync

// ---- core/sev_eval.sv ----
// Evaluator for two safety output channels with restart interlock and contactor check
`timescale 1ns/1ps
module sev_eval
  import sev_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Field pins
  input  sev_pins_in_t       pins_in,
  output sev_pins_out_t      pins_out,
  // Software port
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output logic      [31:0]   rdata,
  // Interrupt
  output logic               irq
);

  // Synchronised pins, one flop pair per line
  sev_pins_in_t pins_s;

  sev_sync #(
    .W       ($bits(sev_pins_in_t))
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d_async (pins_in),
    .q_sync  (pins_s)
  );

  // Each channel kept as its own signal
  wire ch_a_on  = pins_s.safety_out_a;
  wire ch_b_on  = pins_s.safety_out_b;
  wire both_on  = ch_a_on & ch_b_on;
  wire any_off  = ~ch_a_on | ~ch_b_on;
  wire differ   = ch_a_on ^ ch_b_on;
  wire fb_a_rel = pins_s.feedback_a;
  wire fb_b_rel = pins_s.feedback_b;
  wire fb_both_rel = fb_a_rel & fb_b_rel;
  wire btn      = pins_s.reset_pushbutton;

  // Registers
  sev_state_t   state_reg, state_next;
  logic [31:0]  ctrl_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [15:0]  disc_lim_reg;
  logic [15:0]  tick_cnt_reg;
  logic [15:0]  disc_cnt_reg;
  logic [11:0]  edm_cnt_reg;
  logic [11:0]  btn_cnt_reg;
  logic [7:0]   flash_cnt_reg;
  logic         flash_reg;
  logic         btn_prev_reg;
  logic         btn_armed_reg;
  logic         btn_stuck_reg;
  logic         edm_fault_reg;
  sev_pins_out_t out_reg;

  // Millisecond tick
  wire tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Discrepancy timer, restarts whenever the channels agree
  wire disc_expired = differ && (disc_cnt_reg >= disc_lim_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disc_cnt_reg <= 16'h0000;
    end else if (!differ) begin
      disc_cnt_reg <= 16'h0000;
    end else if (tick && !disc_expired) begin
      disc_cnt_reg <= disc_cnt_reg + 16'h0001;
    end
  end

  // Reset pushbutton: press, hold within window, then release
  wire btn_press   = btn & ~btn_prev_reg;
  wire btn_release = ~btn & btn_prev_reg;
  wire btn_long    = btn_cnt_reg >= BTN_MAX_MS;
  wire btn_valid   = btn_release && btn_armed_reg && !btn_stuck_reg &&
                     (btn_cnt_reg >= BTN_MIN_MS);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn_prev_reg <= 1'b1;
      btn_cnt_reg  <= 12'h000;
    end else begin
      btn_prev_reg <= btn;
      if (!btn) begin
        btn_cnt_reg <= 12'h000;
      end else if (tick && !btn_long) begin
        btn_cnt_reg <= btn_cnt_reg + 12'h001;
      end
    end
  end

  // A press counts only if it starts while a reset is awaited
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn_armed_reg <= 1'b0;
      btn_stuck_reg <= 1'b1;
    end else begin
      if (btn_press) begin
        btn_armed_reg <= (state_reg == SEV_READY);
      end else if (state_reg != SEV_READY || btn_release) begin
        btn_armed_reg <= 1'b0;
      end
      // Held too long counts as jammed; the flag set by reset clears two clocks after the button reads released, never while it is held
      if (btn && btn_long) begin
        btn_stuck_reg <= 1'b1;
      end else if (!btn && !btn_prev_reg) begin
        btn_stuck_reg <= 1'b0;
      end
    end
  end

  // Contactor feedback supervision
  wire cmd_on   = out_reg.contactor_a;
  wire fb_match = cmd_on ? ~(fb_a_rel | fb_b_rel) : fb_both_rel;
  wire edm_late = edm_cnt_reg >= EDM_MS;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edm_cnt_reg <= 12'h000;
    end else if (fb_match) begin
      edm_cnt_reg <= 12'h000;
    end else if (tick && !edm_late) begin
      edm_cnt_reg <= edm_cnt_reg + 12'h001;
    end
  end

  // Fault stays until both contacts drop again, which blocks restart meanwhile
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edm_fault_reg <= 1'b0;
    end else if (edm_late && !fb_match) begin
      edm_fault_reg <= 1'b1;
    end else if (!cmd_on && fb_both_rel) begin
      edm_fault_reg <= 1'b0;
    end
  end

  // Main sequence
  wire run_en   = ctrl_reg[CTRL_RUN_EN_B];
  // Restart needs a clean press, dropped contacts and no open fault
  wire start_ok = btn_valid && fb_both_rel && !edm_fault_reg && run_en;
  wire stop_run = any_off || edm_fault_reg || !run_en;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEV_TRIP: begin
        if (both_on) state_next = SEV_READY;
      end
      SEV_READY: begin
        if (any_off)
          state_next = SEV_TRIP;
        else if (start_ok)
          state_next = SEV_RUN;
      end
      SEV_RUN: begin
        if (stop_run)
          state_next = SEV_TRIP;
      end
      SEV_LOCK: begin
        state_next = SEV_LOCK;
      end
      default: begin
        state_next = SEV_LOCK;
      end
    endcase
    if (disc_expired)
      state_next = SEV_LOCK;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= SEV_TRIP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ready lamp flasher
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_cnt_reg <= 8'h00;
      flash_reg     <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_reg == FLASH_MS - 8'h01) begin
        flash_cnt_reg <= 8'h00;
        flash_reg     <= ~flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 8'h01;
      end
    end
  end

  // Outputs from flops; contactors on only while running with both channels on
  wire run_next   = (state_next == SEV_RUN) && both_on;
  wire trip_next  = (state_next == SEV_TRIP) || (state_next == SEV_LOCK);
  wire ready_next = (state_next == SEV_READY) && flash_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg.contactor_a      <= run_next;
      out_reg.contactor_b      <= run_next;
      out_reg.tripped_lamp     <= trip_next;
      out_reg.reset_ready_lamp <= ready_next;
    end
  end

  assign pins_out = out_reg;

  // Events, set wins over a software clear
  logic [ST_W-1:0] ev;
  assign ev[ST_TRIP_B]  = (state_reg == SEV_RUN) && (state_next == SEV_TRIP);
  assign ev[ST_DISC_B]  = disc_expired;
  assign ev[ST_EDM_B]   = edm_late && !fb_match;
  assign ev[ST_STUCK_B] = btn && btn_long;
  assign ev[ST_LOCK_B]  = (state_next == SEV_LOCK) && (state_reg != SEV_LOCK);
  assign ev[ST_READY_B] = (state_reg == SEV_TRIP) && (state_next == SEV_READY);

  // Register decode
  wire sel_ctrl   = (addr == ADDR_CTRL);
  wire sel_status = (addr == ADDR_STATUS);
  wire sel_mask   = (addr == ADDR_MASK);
  wire sel_state  = (addr == ADDR_STATE);
  wire sel_disc   = (addr == ADDR_DISC);

  wire wr_ctrl = wr_en && sel_ctrl;
  wire wr_mask = wr_en && sel_mask;
  wire wr_disc = wr_en && sel_disc;
  wire [ST_W-1:0] w1c = (wr_en && sel_status) ? wdata[ST_W-1:0] : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= CTRL_RST;
      mask_reg     <= MASK_RST[ST_W-1:0];
      disc_lim_reg <= DISC_MS_RST;
      status_reg   <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata;
      end
      if (wr_mask) begin
        mask_reg <= wdata[ST_W-1:0];
      end
      if (wr_disc) begin
        disc_lim_reg <= wdata[15:0];
      end
      status_reg <= (status_reg & ~w1c) | ev;
    end
  end

  // Live state view, fields packed from bit 0 upward
  wire [31:0] state_word = {15'h0000,
                            edm_fault_reg, btn_stuck_reg, out_reg,
                            pins_s, state_reg, 1'b0, differ};

  wire [31:0] status_word = {{(32-ST_W){1'b0}}, status_reg};
  wire [31:0] mask_word   = {{(32-ST_W){1'b0}}, mask_reg};

  wire [31:0] rd_mux =
    sel_ctrl   ? ctrl_reg :
    sel_status ? status_word :
    sel_mask   ? mask_word :
    sel_state  ? state_word :
    sel_disc   ? {16'h0000, disc_lim_reg} :
                 32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    // Zero outside the answer cycle, so stale data never lingers
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule : sev_eval

// ---- verif/sev_chk.sv ----
// Checker for the evaluator's field-pin behaviour
`timescale 1ns/1ps
module sev_chk
  import sev_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic    clk_sys,
  input wire logic    rst,
  // Field pins
  input sev_pins_in_t  pins_in,
  input sev_pins_out_t pins_out
);
  // Margins cover sync delay and ms tick granularity
  localparam int LOCK_C = 100 * TICK_CYCLES + 30;
  localparam int EDM_C  = 300 * TICK_CYCLES + 30;
  logic [31:0] dcnt_reg;
  logic [31:0] ecnt_reg;
  wire         ch_differ = pins_in.safety_out_a != pins_in.safety_out_b;
  wire         fb_bad    = pins_out.contactor_a && pins_in.feedback_a;
  logic        seen_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dcnt_reg <= 32'h0000_0000;
      ecnt_reg <= 32'h0000_0000;
      seen_reg <= 1'b0;
    end else begin
      dcnt_reg <= ch_differ ? dcnt_reg + 32'h0000_0001 : 32'h0000_0000;
      ecnt_reg <= fb_bad ? ecnt_reg + 32'h0000_0001 : 32'h0000_0000;
      seen_reg <= pins_in.reset_pushbutton | (seen_reg & ~pins_out.contactor_a);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_off_drops: assert property (!(pins_in.safety_out_a && pins_in.safety_out_b)
    |-> ##3 !pins_out.contactor_a && !pins_out.contactor_b) else $error("contactor held on");
  a_contactor_pair: assert property (pins_out.contactor_a == pins_out.contactor_b)
    else $error("contactors differ");
  a_lamps_off_run: assert property (pins_out.contactor_a |->
    !pins_out.tripped_lamp && !pins_out.reset_ready_lamp) else $error("lamp lit in run");
  a_feedback_first: assert property ($rose(pins_out.contactor_a) |->
    $past(pins_in.feedback_a, 3) && $past(pins_in.feedback_b, 3)) else $error("start on bad feedback");
  a_release_first: assert property ($rose(pins_out.contactor_a) |->
    !$past(pins_in.reset_pushbutton, 3)) else $error("start before release");
  a_press_first: assert property ($rose(pins_out.contactor_a) |-> seen_reg)
    else $error("start without press");
  a_lock_on_diff: assert property (dcnt_reg == 32'(LOCK_C) |-> pins_out.tripped_lamp
    && !pins_out.contactor_a && !pins_out.reset_ready_lamp) else $error("no lock-out");
  a_edm_drop: assert property (ecnt_reg == 32'(EDM_C) |-> !pins_out.contactor_a)
    else $error("contactor fault missed");
  cover property ($rose(pins_out.contactor_a));
  cover property ($fell(pins_out.contactor_a));
  cover property (dcnt_reg == 32'(LOCK_C));
endmodule : sev_chk

bind sev_eval sev_chk #(.TICK_CYCLES(TICK_CYCLES)) u_sev_chk (
  .clk_sys (clk_sys),
  .rst     (rst),
  .pins_in (pins_in),
  .pins_out(pins_out)
);

// ---- verif/sev_sensor_model.sv ----
// Behavioural light-path sensor with two switching channels
`timescale 1ns/1ps
module sev_sensor_model (
  // Scenario controls
  input  wire logic clear,
  input  wire logic fault,
  // Safety channels
  output logic      safety_out_a,
  output logic      safety_out_b
);
  // Fault drops one channel only, like a shorted line
  assign safety_out_a = clear && !fault;
  assign safety_out_b = clear;
endmodule : sev_sensor_model

// ---- verif/testbench.sv ----
// Self-checking bench for the safety output evaluator
`timescale 1ns/1ps
module testbench;
  import sev_pkg::*;
  localparam int TK = 10;
  typedef struct {logic [7:0] a; logic [31:0] e;} sev_row_t;
  logic          clk_sys = 0;
  logic          rst = 1;
  logic          wr_en = 0;
  logic          rd_en = 0;
  logic          clear = 0;
  logic          fault = 0;
  logic          fb_a = 1;
  logic          fb_b = 1;
  logic          btn = 0;
  logic          sa;
  logic          sb;
  logic          irq;
  logic [7:0]    addr = 8'h00;
  logic [31:0]   wdata = 32'h0000_0000;
  logic [31:0]   rdata;
  logic [31:0]   d;
  sev_pins_in_t  pins_in;
  sev_pins_out_t pins_out;
  int            fail_count = 0;
  int            tests_run = 0;
  int            cyc = 0;
  sev_row_t      rows[6];
  always #10 clk_sys = ~clk_sys;
  assign pins_in = '{sa, sb, fb_a, fb_b, btn};
  sev_sensor_model u_sev_sensor_model (.clear(clear), .fault(fault),
    .safety_out_a(sa), .safety_out_b(sb));
  sev_eval #(.TICK_CYCLES(TK)) u_sev_eval (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in),
    .pins_out(pins_out), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .irq(irq));
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task cy(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cy
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask : rd
  // Hold the button n cycles, then let the result settle
  task press(input int n);
    @(posedge clk_sys);
    btn <= 1'b1;
    cy(n);
    btn <= 1'b0;
    cy(20);
  endtask : press
  task done(input string n);
    $display("%0t test %s done", $time, n);
  endtask : done
  task tally_and_finish;
    $display("%0d checks, %0d failures", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    rows = '{'{ADDR_CTRL, CTRL_RST}, '{ADDR_STATUS, 32'h0000_0000}, '{ADDR_MASK, MASK_RST},
      '{ADDR_STATE, 32'h0000_1184}, '{ADDR_DISC, 32'h0000_0064}, '{8'h14, 32'h0000_0000}};
    cy(2);
    rst <= 1'b0;
    cy(10);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    done("registers");
    clear <= 1'b1;
    cy(10);
    rd(ADDR_STATE);
    chk(32'(d[5:2]), 32'h2);
    chk(32'(pins_out[1]), 32'h0);
    press(600);
    chk(32'(pins_out[3:2]), 32'h3);
    fb_a <= 1'b0;
    fb_b <= 1'b0;
    done("start");
    cy(5);
    clear <= 1'b0;
    cy(5);
    chk(32'(pins_out), 32'h2);
    fb_a <= 1'b1;
    fb_b <= 1'b1;
    wr(ADDR_MASK, 32'h0000_0001);
    chk(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h0000_0001);
    chk(32'(irq), 32'h0);
    done("trip");
    clear <= 1'b1;
    cy(50);
    chk(32'(pins_out[3:2]), 32'h0);
    press(100);
    chk(32'(pins_out[3:2]), 32'h0);
    fb_a <= 1'b0;
    press(600);
    chk(32'(pins_out[3:2]), 32'h0);
    fb_a <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0000);
    press(600);
    chk(32'(pins_out[3:2]), 32'h0);
    wr(ADDR_CTRL, CTRL_RST);
    done("interlock");
    press(600);
    chk(32'(pins_out[3:2]), 32'h3);
    cy(3100);
    chk(32'(pins_out[3:2]), 32'h0);
    rd(ADDR_STATUS);
    chk(32'(d[2]), 32'h1);
    done("feedback");
    press(30100);
    rd(ADDR_STATUS);
    chk(32'(d[3]), 32'h1);
    chk(32'(pins_out[3:2]), 32'h0);
    done("stuck");
    fault <= 1'b1;
    cy(1100);
    rd(ADDR_STATE);
    chk(32'(d[5:2]), 32'h8);
    rd(ADDR_STATUS);
    chk(32'(d[ST_DISC_B]), 32'h1);
    chk(32'(d[ST_LOCK_B]), 32'h1);
    fault <= 1'b0;
    press(600);
    rd(ADDR_STATE);
    chk(32'(d[5:2]), 32'h8);
    done("lockout");
    rst <= 1'b1;
    cy(2);
    rst <= 1'b0;
    cy(10);
    rd(ADDR_STATE);
    chk(32'(d[5:2]), 32'h2);
    d = 32'(pins_out[0]);
    cy(int'(FLASH_MS) * TK);
    chk(32'(pins_out[0]), d ^ 32'h0000_0001);
    done("reset");
    tally_and_finish();
  end
endmodule : testbench
